// *** otp_pkg.sv ***
// Shared constants for the one-time-programmable row sequencer
//
// Operation
// - A frame has 32 bits: bit 31 write flag, bits 30-23 address, bits 20-5 payload, 4-0 CRC.
// - The block replaces bits 15-13 of the write data with its own checksum of the word.
// - A burn is refused unless configuration bits 14-12 hold 111.
// - Writing the operation register with code 01 in bits 5-4 (frame bits 10-9) burns the row in bits 3-0 (frame bits 8-5).
// - Writing the operation register with code 10 in bits 5-4 (frame bits 10-9) reads the row in bits 3-0 (frame bits 8-5).
// - Status bit 4 is busy while an operation runs and clear once it has finished.
// - Status bit 6 is the error flag, set by a refused operation and cleared by an accepted one.
// - Read data come back in the frame after the one that asked for them.
// - A response echoes the previously read address in bits 28-21 and data in bits 20-5.
// - After power-on a device with an unburned identity field enters programming mode.
// - In programming mode a row index outside 8 to 12 sets the error flag.
// - When row 12 bits 15-13 read 111, burns to the user rows are refused.
package otp_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS   = 32;
    localparam int FR_WRITE_BIT = 31;
    localparam int FR_ADDR_HI   = 30;
    localparam int FR_ADDR_LO   = 23;
    localparam int FR_DATA_HI   = 20;
    localparam int FR_DATA_LO   = 5;
    localparam int FR_CRC_HI    = 4;
    localparam int RSP_ADDR_HI  = 28;
    localparam int RSP_ADDR_LO  = 21;
    localparam logic [4:0] CRC_INIT = 5'h1f;
    localparam logic [4:0] CRC_POLY = 5'h05;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OPERATION_COMMAND = 8'h30;
    localparam logic [7:0] ADDR_PROGRAM_CONFIG    = 8'h31;
    localparam logic [7:0] ADDR_WRITE_DATA        = 8'h32;
    localparam logic [7:0] ADDR_OPERATION_STATUS  = 8'h34;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int OP_CODE_HI  = 10;
    localparam int OP_CODE_LO  = 9;
    localparam int OP_ROW_HI   = 8;
    localparam int OP_ROW_LO   = 5;
    localparam logic [1:0] OP_BURN = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam int HV_DECODE_HI = 14;
    localparam int HV_DECODE_LO = 12;
    localparam logic [2:0] HV_DECODE_ON = 3'h7;
    localparam int CHK_HI = 15;
    localparam int CHK_LO = 13;
    localparam logic [2:0] PROTECT_SET = 3'h7;
    localparam int ST_BUSY_BIT  = 4;
    localparam int ST_PROG_BIT  = 5;
    localparam int ST_ERROR_BIT = 6;
    localparam logic [3:0] ROW_IDENT   = 4'h9;
    localparam logic [3:0] ROW_USR_MIN = 4'h8;
    localparam logic [3:0] ROW_USR_MAX = 4'hc;
    localparam logic [3:0] ROW_PROTECT = 4'hc;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int BURN_TIME_NS  = 100000;
    localparam int READ_TIME_NS  = 1000;
    localparam int BURN_CYCLES   = (BURN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYCLES   = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        OTP_IDLE = 3'b001,
        OTP_RUN  = 3'b010,
        OTP_DONE = 3'b100
    } otp_state_t;

endpackage

// *** otp_crc5.sv ***
// Five-bit frame check over the upper 27 bits of a frame
`timescale 1ns/100ps
module otp_crc5
    import otp_pkg::*;
(
    // Frame content
    input  wire logic [26:0] data,
    // Check value
    output logic      [4:0]  crc
);
    logic [4:0] acc;
    logic       fb;

    always_comb begin
        acc = CRC_INIT;
        fb  = 1'b0;
        for (int i = 26; i >= 0; i--) begin
            fb  = acc[4] ^ data[i];
            acc = {acc[3:0], 1'b0};
            if (fb) begin
                acc = acc ^ CRC_POLY;
            end
        end
        crc = acc;
    end
endmodule

// *** otp_spi_link.sv ***
// Serial link shifter running on the host serial clock
`timescale 1ns/100ps
module otp_spi_link
    import otp_pkg::*;
(
    // Link clock and reset
    input  wire logic        sclk,
    input  wire logic        reset,
    // Link pins
    input  wire logic        csn_n,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    // Word exchange with the core
    input  wire logic [31:0] tx_word,
    output logic      [31:0] rx_word,
    output logic             rx_toggle
);
    logic [4:0]  rx_cnt_reg;
    logic [30:0] rx_shift_reg;
    logic [4:0]  tx_cnt_reg;
    logic [31:0] tx_shift_reg;

    // ------------------------------------------------------------
    // Receive on falling edge, frame ends at bit 32
    // ------------------------------------------------------------
    always_ff @(negedge sclk or posedge csn_n) begin
        if (csn_n) begin
            rx_cnt_reg <= 5'h00;
        end else begin
            rx_cnt_reg <= rx_cnt_reg + 5'h01;
        end
    end

    always_ff @(negedge sclk) begin
        rx_shift_reg <= {rx_shift_reg[29:0], mosi};
    end

    always_ff @(negedge sclk or posedge reset) begin
        if (reset) begin
            rx_word   <= 32'h0000_0000;
            rx_toggle <= 1'b0;
        end else if (!csn_n && rx_cnt_reg == 5'h1f) begin
            rx_word   <= {rx_shift_reg, mosi};
            rx_toggle <= ~rx_toggle;
        end
    end

    // ------------------------------------------------------------
    // Transmit on rising edge, first edge loads the response
    // ------------------------------------------------------------
    always_ff @(posedge sclk or posedge csn_n) begin
        if (csn_n) begin
            tx_cnt_reg <= 5'h00;
            miso_oe    <= 1'b0;
        end else begin
            tx_cnt_reg <= tx_cnt_reg + 5'h01;
            miso_oe    <= 1'b1;
        end
    end

    always_ff @(posedge sclk) begin
        if (tx_cnt_reg == 5'h00) begin
            tx_shift_reg <= {tx_word[30:0], 1'b0};
            miso         <= tx_word[31];
        end else begin
            tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
            miso         <= tx_shift_reg[31];
        end
    end
endmodule

// *** otp_row_program_sequencer.sv ***
// Row burn and read sequencer reached through 32-bit serial frames
`timescale 1ns/100ps
module otp_row_program_sequencer
    import otp_pkg::*;
#(
    parameter int ROWS = 16
)
(
    // Core clock and reset
    input  wire logic mclk,
    input  wire logic reset,
    // Serial link
    input  wire logic sclk,
    input  wire logic csn_n,
    input  wire logic mosi,
    output logic      miso,
    output logic      miso_oe
);
    logic [31:0]      rx_word;
    logic             rx_toggle;
    logic             tog_s1_reg;
    logic             tog_s2_reg;
    logic             tog_s3_reg;
    logic             tog_seen_reg;
    logic             frame_evt;
    logic [4:0]       rx_crc;
    logic             crc_ok;
    logic             frame_wr;
    logic [7:0]       frame_addr;
    logic [15:0]      frame_data;
    logic [15:0]      op_reg;
    logic [15:0]      cfg_reg;
    logic [15:0]      din_reg;
    logic [15:0]      dout_reg;
    logic             busy_reg;
    logic             error_reg;
    logic             prog_reg;
    logic [1:0]       boot_reg;
    logic [15:0]      rows_reg [ROWS];
    otp_state_t       state_reg;
    otp_state_t       state_next;
    logic [11:0]      cnt_reg;
    logic             burn_op_reg;
    logic [3:0]       row_reg;
    logic             start;
    logic             bad_op;
    logic [1:0]       start_code;
    logic [3:0]       start_row;
    logic [2:0]       chk;
    logic [15:0]      status;
    logic [15:0]      rd_value;
    logic [7:0]       rsp_addr_reg;
    logic [15:0]      rsp_data_reg;
    logic [4:0]       tx_crc;
    logic [31:0]      tx_word_reg;

    // ------------------------------------------------------------
    // Link side and frame crossing
    // ------------------------------------------------------------
    otp_spi_link u_link (
        .sclk      (sclk),
        .reset     (reset),
        .csn_n     (csn_n),
        .mosi      (mosi),
        .miso      (miso),
        .miso_oe   (miso_oe),
        .tx_word   (tx_word_reg),
        .rx_word   (rx_word),
        .rx_toggle (rx_toggle)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            tog_s1_reg   <= 1'b0;
            tog_s2_reg   <= 1'b0;
            tog_s3_reg   <= 1'b0;
            tog_seen_reg <= 1'b0;
        end else begin
            tog_s1_reg   <= rx_toggle;
            tog_s2_reg   <= tog_s1_reg;
            tog_s3_reg   <= tog_s2_reg;
            if (tog_s2_reg == tog_s3_reg) begin
                tog_seen_reg <= tog_s3_reg;
            end
        end
    end

    assign frame_evt = (tog_s2_reg == tog_s3_reg) && (tog_s3_reg != tog_seen_reg);

    // ------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------
    otp_crc5 u_rx_crc (
        .data (rx_word[31:5]),
        .crc  (rx_crc)
    );

    assign crc_ok     = frame_evt && (rx_crc == rx_word[FR_CRC_HI:0]);
    assign frame_wr   = rx_word[FR_WRITE_BIT];
    assign frame_addr = rx_word[FR_ADDR_HI:FR_ADDR_LO];
    assign frame_data = rx_word[FR_DATA_HI:FR_DATA_LO];

    // Checksum: count of ones in bits 12-0, modulo eight
    always_comb begin
        chk = 3'h0;
        for (int i = 0; i < CHK_LO; i++) begin
            chk = chk + {2'b00, frame_data[i]};
        end
    end

    // ------------------------------------------------------------
    // Registers written by the host
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            din_reg <= RESET_WORD;
        end else if (crc_ok && frame_wr && frame_addr == ADDR_WRITE_DATA) begin
            din_reg <= {chk, frame_data[CHK_LO-1:0]};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_reg <= RESET_WORD;
        end else if (crc_ok && frame_wr && frame_addr == ADDR_PROGRAM_CONFIG) begin
            cfg_reg <= frame_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            op_reg <= RESET_WORD;
        end else if (crc_ok && frame_wr && frame_addr == ADDR_OPERATION_COMMAND) begin
            op_reg <= frame_data;
        end
    end

    // ------------------------------------------------------------
    // Programming mode entry after reset
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            boot_reg <= 2'h0;
            prog_reg <= 1'b0;
        end else if (boot_reg != 2'h3) begin
            boot_reg <= boot_reg + 2'h1;
            if (boot_reg == 2'h2) begin
                prog_reg <= (rows_reg[ROW_IDENT][CHK_HI:CHK_LO] == 3'h0);
            end
        end
    end

    // ------------------------------------------------------------
    // Operation start and checks
    // ------------------------------------------------------------
    assign start_code = frame_data[OP_CODE_HI-FR_DATA_LO:OP_CODE_LO-FR_DATA_LO];
    assign start_row  = frame_data[OP_ROW_HI-FR_DATA_LO:OP_ROW_LO-FR_DATA_LO];
    assign start      = crc_ok && frame_wr && frame_addr == ADDR_OPERATION_COMMAND
                        && state_reg == OTP_IDLE && prog_reg;

    always_comb begin
        bad_op = 1'b0;
        if (start_code != OP_BURN && start_code != OP_READ) begin
            bad_op = 1'b1;
        end
        if (frame_data[FR_DATA_HI-FR_DATA_LO:OP_CODE_HI+1-FR_DATA_LO] != 10'h000) begin
            bad_op = 1'b1;
        end
        if (start_row < ROW_USR_MIN || start_row > ROW_USR_MAX) begin
            bad_op = 1'b1;
        end
        if (start_code == OP_BURN && cfg_reg[HV_DECODE_HI:HV_DECODE_LO] != HV_DECODE_ON) begin
            bad_op = 1'b1;
        end
        if (start_code == OP_BURN && rows_reg[ROW_PROTECT][CHK_HI:CHK_LO] == PROTECT_SET) begin
            bad_op = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Operation sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            OTP_IDLE: begin
                if (start && !bad_op) begin
                    state_next = OTP_RUN;
                end
            end
            OTP_RUN: begin
                if (cnt_reg == 12'h000) begin
                    state_next = OTP_DONE;
                end
            end
            OTP_DONE: begin
                state_next = OTP_IDLE;
            end
            default: begin
                state_next = OTP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= OTP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_reg     <= 12'h000;
            burn_op_reg <= 1'b0;
            row_reg     <= 4'h0;
        end else if (start && !bad_op) begin
            burn_op_reg <= (start_code == OP_BURN);
            row_reg     <= start_row;
            cnt_reg     <= (start_code == OP_BURN) ? 12'(BURN_CYCLES - 1) : 12'(READ_CYCLES - 1);
        end else if (state_reg == OTP_RUN && cnt_reg != 12'h000) begin
            cnt_reg <= cnt_reg - 12'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            busy_reg  <= 1'b0;
            error_reg <= 1'b0;
        end else if (start) begin
            busy_reg  <= !bad_op;
            error_reg <= bad_op;
        end else if (state_reg == OTP_DONE) begin
            busy_reg <= 1'b0;
        end
    end

    // Cell array: burning can only set bits
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int r = 0; r < ROWS; r++) begin
                rows_reg[r] <= RESET_WORD;
            end
            dout_reg <= RESET_WORD;
        end else if (state_reg == OTP_DONE) begin
            if (burn_op_reg) begin
                rows_reg[row_reg] <= rows_reg[row_reg] | din_reg;
            end else begin
                dout_reg <= rows_reg[row_reg];
            end
        end
    end

    // ------------------------------------------------------------
    // Read path, answered one frame late
    // ------------------------------------------------------------
    always_comb begin
        status = 16'h0000;
        status[ST_BUSY_BIT]  = busy_reg;
        status[ST_PROG_BIT]  = prog_reg;
        status[ST_ERROR_BIT] = error_reg;
    end

    always_comb begin
        unique case (frame_addr)
            ADDR_OPERATION_COMMAND: rd_value = op_reg;
            ADDR_PROGRAM_CONFIG:    rd_value = cfg_reg;
            ADDR_WRITE_DATA:        rd_value = din_reg;
            ADDR_OPERATION_STATUS:  rd_value = status;
            default:                rd_value = 16'h0000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_addr_reg <= 8'h00;
            rsp_data_reg <= 16'h0000;
        end else if (crc_ok && !frame_wr) begin
            rsp_addr_reg <= frame_addr;
            rsp_data_reg <= rd_value;
        end
    end

    otp_crc5 u_tx_crc (
        .data ({3'b000, rsp_addr_reg, rsp_data_reg}),
        .crc  (tx_crc)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_word_reg <= 32'h0000_0000;
        end else begin
            tx_word_reg <= {3'b000, rsp_addr_reg, rsp_data_reg, tx_crc};
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    bad_crc_ignored_a: assert property (
        frame_evt && rx_crc != rx_word[4:0] |=> $stable(op_reg) && $stable(din_reg)
            && $stable(cfg_reg) && $stable(rsp_addr_reg))
        else $error("frame with bad check changed state");
    burn_hv_gate_a: assert property (
        start && start_code == OP_BURN && cfg_reg[14:12] != 3'h7 |=> error_reg && !busy_reg)
        else $error("burn ran without forced decode");
    row_range_a: assert property (
        start && (start_row < 4'h8 || start_row > 4'hc) |=> error_reg)
        else $error("row outside range not flagged");
    protect_gate_a: assert property (
        start && start_code == OP_BURN && rows_reg[12][15:13] == 3'h7 |=> error_reg)
        else $error("burn ran on protected area");
    busy_span_a: assert property (
        $rose(busy_reg) && burn_op_reg |-> busy_reg [*8])
        else $error("busy dropped early");
    busy_ends_a: assert property (
        $rose(busy_reg) && !burn_op_reg |-> ##[19:21] !busy_reg)
        else $error("read did not finish in time");
    checksum_load_a: assert property (
        crc_ok && frame_wr && frame_addr == 8'h32 |=> din_reg[15:13] == $past(chk))
        else $error("checksum not inserted");
    echo_addr_a: assert property (
        crc_ok && !frame_wr |=> ##1 tx_word_reg[28:21] == $past(frame_addr, 2))
        else $error("response address not echoed");
    burn_result_a: assert property (
        state_reg == OTP_DONE && burn_op_reg |=> (rows_reg[row_reg] & din_reg) == din_reg)
        else $error("row not burned");
    prog_entry_a: assert property (
        boot_reg == 2'h2 && rows_reg[9][15:13] == 3'h0 |=> prog_reg)
        else $error("programming mode not entered");
    good_start_a: assert property (
        start && !bad_op |=> busy_reg && !error_reg)
        else $error("valid start not accepted");
    busy_clear_a: assert property (
        state_reg == OTP_DONE |=> !busy_reg)
        else $error("busy still set after finish");
    op_zero_field_a: assert property (
        start && frame_data[15:6] != 10'h000 |=> error_reg && !busy_reg)
        else $error("nonzero upper operation field accepted");
endmodule

// *** otp_host_model.sv ***
// Host serial master model driving 32-bit frames into the row sequencer
`timescale 1ns/100ps
module otp_host_model (
    // Link pins
    output logic      sclk,
    output logic      csn_n,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic oe_seen;

    // ------------------------------------------------------------
    // Frame check
    // ------------------------------------------------------------
    function automatic logic [4:0] crc5(input logic [26:0] d);
        logic [4:0] c;
        c = 5'h1f;
        for (int i = 26; i >= 0; i--) begin
            c = {c[3:0], 1'b0} ^ ((c[4] ^ d[i]) ? 5'h05 : 5'h00);
        end
        return c;
    endfunction

    initial begin
        sclk    = 1'b0;
        csn_n   <= 1'b1;
        mosi    = 1'b1;
        oe_seen = 1'b1;
    end

    // ------------------------------------------------------------
    // One frame, MSB first; bad_crc spoils the check bits
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] data,
                        input logic bad_crc, output logic [31:0] resp);
        logic [31:0] w;
        w = {wr, addr, 2'b10, data, 5'h00};
        w[4:0] = crc5(w[31:5]) ^ {5{bad_crc}};
        #7.3;
        csn_n <= 1'b0;
        for (int k = 31; k >= 0; k--) begin
            mosi <= w[k];
            #31 sclk <= 1'b1;
            #63 resp[k] = miso;
            oe_seen = oe_seen & miso_oe;
            sclk <= 1'b0;
            #31;
        end
        csn_n <= 1'b1;
        mosi  <= ~w[0];
        #1000;
    endtask
endmodule

// *** test_otp_row_program_sequencer.sv ***
// Self-checking bench for the row burn and read sequencer
`timescale 1ns/100ps
module test_otp_row_program_sequencer;
    import otp_pkg::*;

    logic        mclk;
    logic        reset;
    logic        sclk;
    logic        csn_n;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    int          num_errors;
    int          checks_done;
    logic [31:0] rsp;
    logic [15:0] st;
    logic [15:0] word;
    logic [15:0] din;

    otp_row_program_sequencer otp_row_program_sequencer_inst (
        .mclk(mclk), .reset(reset), .sclk(sclk), .csn_n(csn_n),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
    otp_host_model otp_host_model_inst (
        .sclk(sclk), .csn_n(csn_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic final_report();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] with_chk(input logic [15:0] d);
        return {3'($countones(d[12:0])), d[12:0]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        otp_host_model_inst.xfer(1'b1, a, d, 1'b0, rsp);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        otp_host_model_inst.xfer(1'b0, a, 16'h0000, 1'b0, rsp);
        otp_host_model_inst.xfer(1'b0, a, 16'h0000, 1'b0, rsp);
        check("echo", {8'h00, a}, {8'h00, rsp[28:21]});
        check("rsp_crc", {11'h000, otp_host_model_inst.crc5(rsp[31:5])}, {11'h000, rsp[4:0]});
        d = rsp[20:5];
    endtask

    task automatic run(input logic [1:0] code, input logic [3:0] row, input logic err);
        int n;
        n = 0;
        wr(ADDR_OPERATION_COMMAND, {10'h000, code, row});
        rd(ADDR_OPERATION_STATUS, st);
        if (code == OP_BURN) begin
            check("busy", {15'h0000, ~err}, {15'h0000, st[ST_BUSY_BIT]});
        end
        while (st[ST_BUSY_BIT] !== 1'b0 && n < 40) begin
            rd(ADDR_OPERATION_STATUS, st);
            n++;
        end
        check("busy_end", 16'h0000, {15'h0000, st[ST_BUSY_BIT]});
        check("error", {15'h0000, err}, {15'h0000, st[ST_ERROR_BIT]});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        num_errors  = 0;
        checks_done = 0;
        reset <= 1'b1;
        void'($urandom(63438));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(ADDR_OPERATION_STATUS, st);
        check("status", 16'h0020, st & 16'h0070);
        for (int i = 0; i < 6; i++) begin
            word = (i == 0) ? 16'hffff : 16'($urandom);
            wr(ADDR_WRITE_DATA, word);
            rd(ADDR_WRITE_DATA, din);
            check("din_chk", with_chk(word), din);
            otp_host_model_inst.xfer(1'b1, ADDR_WRITE_DATA, ~word, 1'b1, rsp);
            rd(ADDR_WRITE_DATA, din);
            check("bad_crc", with_chk(word), din);
        end
        wr(ADDR_PROGRAM_CONFIG, 16'h6000);
        run(OP_BURN, 4'h8, 1'b1);
        wr(ADDR_PROGRAM_CONFIG, 16'h7000);
        wr(ADDR_OPERATION_COMMAND, 16'h0418);
        rd(ADDR_OPERATION_STATUS, st);
        check("upper_field", 16'h0040, st & 16'h0050);
        run(OP_BURN, 4'h7, 1'b1);
        run(OP_BURN, 4'hd, 1'b1);
        run(OP_READ, 4'h0, 1'b1);
        run(2'h3, 4'h9, 1'b1);
        run(OP_READ, 4'ha, 1'b0);
        run(OP_BURN, 4'h8, 1'b0);
        wr(ADDR_WRITE_DATA, 16'h007f);
        run(OP_BURN, 4'hc, 1'b0);
        run(OP_BURN, 4'h9, 1'b1);
        run(OP_READ, 4'hc, 1'b0);
        check("miso_oe", 16'h0001, {15'h0000, otp_host_model_inst.oe_seen});
        final_report();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        final_report();
    end
endmodule
